/* inc/rdc_regs.svh */
// Purpose: register indices, fields, codes and timing of the direct command block
// Assumes: byte address on the bus is four times the register index
// Notes: figures shared by the bench and the rtl live here; sequencer codes live in the package
`ifndef RDC_REGS_SVH
`define RDC_REGS_SVH
`define RDC_IX_CMD 6'h00
`define RDC_IX_CAL 6'h10
`define RDC_IX_TST 6'h11
`define RDC_IX_OPT 6'h12
`define RDC_IX_ADC 6'h19
`define RDC_IX_LEN1 6'h1d
`define RDC_IX_LEN2 6'h1e
`define RDC_IX_FIFO 6'h1f
`define RDC_IX_STAT 6'h20
`define RDC_LEN1_RST 8'h00
`define RDC_LEN2_RST 8'h00
`define RDC_CAL_RST 8'h00
`define RDC_FLAG_POS 0
`define RDC_BITS_LSB 1
`define RDC_CNT_LSB 4
`define RDC_OPT_HP_POS 0
`define RDC_CMD_MSB 7
`define RDC_C_IDLE 8'h80
`define RDC_C_HOP_MAIN 8'h84
`define RDC_C_HOP_AUX 8'h85
`define RDC_C_ADC 8'h87
`define RDC_C_CAL 8'h88
`define RDC_C_CAL_DN 8'h89
`define RDC_C_CAL_UP 8'h8a
`define RDC_C_FIFO_RST 8'h8f
`define RDC_C_TX_CRC 8'h90
`define RDC_C_TX_HDR 8'h91
`define RDC_C_TX_NOCRC 8'h92
`define RDC_C_DLY_NOCRC 8'h93
`define RDC_C_DLY_CRC 8'h94
`define RDC_C_RX_BLOCK 8'h96
`define RDC_C_RX_EN 8'h97
`define RDC_C_QUERY 8'h98
`define RDC_C_QADJ_DN 8'h9c
`define RDC_C_REQ_RN 8'h9f
`define RDC_MSEL_MIX1 3'h1
`define RDC_MSEL_MIX2 3'h2
`define RDC_MSEL_PIN 3'h3
`define RDC_CAL_MAX 4'hf
`define RDC_FIFO_DEPTH 24
`define RDC_CLK_NS 100
`define RDC_ADC_NS 20000
`define RDC_ADC_CYC ((`RDC_ADC_NS + `RDC_CLK_NS - 1) / `RDC_CLK_NS)
`endif

/* inc/rdc_pkg.sv */
// Purpose: shared types of the direct command block
// Assumes: nothing beyond the register header
// Notes: one-hot sequencer codes
package rdc_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_adc = 3'b010,
        st_cal = 3'b100
    } rdc_state_type;
endpackage

/* rtl/rdc_core.sv */
// Purpose: direct command decoder, transmit length registers and data fifo
// Assumes: strobes other than enable_i come from logic on clk_i
// Notes: avalon slave answers every request on its second edge
// Contract
// - length register one holds count bits 11..4, clears on reset and transmit end
// - length register two holds count bits 3..0, partial bits and partial flag
// - partial bit count only counts while the partial flag is one
// - length register two is write only; reads never return written value
// - reads of register two give last received byte valid bits, updated per reception
// - twenty four byte circular fifo sits at the data port
// - every command code has its top bit set
// - fifo reset, receiver block/enable, ack, nak, new handle are decoded; idle falls through ignored
// - 90 crc, 91 crc with header bit, 92 no crc transmit
// - 93 delayed without crc, 94 delayed with crc
// - 98 query with crc5 no receive crc; 99..9c no crc either way
// - 84 selects main divider, also the reset selection
// - 85 selects auxiliary divider until another hop
// - 87 starts one adc conversion into the readout register
// - measurement select 1,2 mixers, 3 pin, rest test
// - 88 runs filter calibration, result into calibration register
// - 89 lowers calibration value one step of sixteen
// - 8a raises calibration value one step, kept in range
// - highpass select option picks which filter section steps adjust
// - fifo reset clears pointers, interrupt flags and collision location
`include "rdc_regs.svh"
module rdc_core #(
    parameter int DEPTH = `RDC_FIFO_DEPTH,
    parameter int ADC_CYCLES = `RDC_ADC_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic [7:0] avm_address_i,
    input wire logic avm_read_i,
    input wire logic avm_write_i,
    input wire logic [31:0] avm_writedata_i,
    output logic [31:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    input wire logic tx_eof_i,
    input wire logic rx_done_i,
    input wire logic [4:0] rx_valid_bits_i,
    input wire logic rx_push_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_pop_i,
    output logic [7:0] tx_data_o,
    output logic [4:0] fifo_count_o,
    input wire logic [7:0] adc_data_i,
    input wire logic cal_done_i,
    input wire logic [7:0] cal_result_i,
    output logic [11:0] complete_byte_count_o,
    output logic partial_flag_o,
    output logic [2:0] partial_byte_bits_o,
    output logic pll_aux_sel_o,
    output logic adc_start_o,
    output logic [2:0] adc_msel_o,
    output logic adc_test_o,
    output logic cal_start_o,
    output logic [3:0] cal_lp_o,
    output logic [3:0] cal_hp_o,
    output logic rx_block_o,
    output logic fifo_reset_o,
    output logic tx_start_o,
    output logic [7:0] tx_cmd_o,
    output logic tx_crc16_o,
    output logic tx_crc5_o,
    output logic rx_crc_off_o,
    output logic header_bit_o,
    output logic tx_delayed_o,
    output rdc_pkg::rdc_state_type seq_state_o
);
    import rdc_pkg::*;

    // enable pin is asynchronous; low acts as reset
    logic en_s1;
    logic en_s2;
    always_ff @(posedge clk_i) begin
        en_s1 <= reset_i ? 1'b0 : enable_i;
        en_s2 <= reset_i ? 1'b0 : en_s1;
    end
    wire rst = reset_i | ~en_s2;

    // bus handshake: first edge captures, second edge completes
    logic ack;
    wire req = avm_read_i | avm_write_i;
    wire take = req & ~ack;
    wire wr_done = avm_write_i & ack;
    wire rd_done = avm_read_i & ack;
    wire [5:0] ix = avm_address_i[7:2];
    wire [7:0] wd = avm_writedata_i[7:0];
    assign avm_waitrequest_o = take;
    always_ff @(posedge clk_i) begin
        ack <= rst ? 1'b0 : take;
    end

    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction

    // registers
    logic [7:0] len1;
    logic [7:0] len2;
    logic [4:0] rx_bits;
    logic [2:0] msel;
    logic opt_hp;
    logic [7:0] adc_reg;
    logic [3:0] lp;
    logic [3:0] hp;
    logic aux;
    logic rxb;

    // command decode
    wire cmd_go = wr_done & hit(ix, `RDC_IX_CMD) & wd[`RDC_CMD_MSB];
    function automatic logic is_c(input logic go, input logic [7:0] w, input logic [7:0] c);
        is_c = go & (w == c);
    endfunction
    rdc_state_type state;
    wire idle_st = (state == st_idle);
    wire c_main = is_c(cmd_go, wd, `RDC_C_HOP_MAIN);
    wire c_aux = is_c(cmd_go, wd, `RDC_C_HOP_AUX);
    wire c_adc = is_c(cmd_go, wd, `RDC_C_ADC) & idle_st;
    wire c_cal = is_c(cmd_go, wd, `RDC_C_CAL) & idle_st;
    wire c_dn = is_c(cmd_go, wd, `RDC_C_CAL_DN) & idle_st;
    wire c_up = is_c(cmd_go, wd, `RDC_C_CAL_UP) & idle_st;
    wire c_frst = is_c(cmd_go, wd, `RDC_C_FIFO_RST);
    wire c_rxb = is_c(cmd_go, wd, `RDC_C_RX_BLOCK);
    wire c_rxe = is_c(cmd_go, wd, `RDC_C_RX_EN);
    // transmit family: 90..94 and 98..9f, 95 and others fall through unused
    wire tx_lo = (wd >= `RDC_C_TX_CRC) & (wd <= `RDC_C_DLY_CRC);
    wire tx_hi = (wd >= `RDC_C_QUERY) & (wd <= `RDC_C_REQ_RN);
    wire tx_go = cmd_go & (tx_lo | tx_hi);

    // length registers and receive bit count
    wire wr_len1 = wr_done & hit(ix, `RDC_IX_LEN1);
    wire wr_len2 = wr_done & hit(ix, `RDC_IX_LEN2);
    always_ff @(posedge clk_i) begin
        if (rst | tx_eof_i) begin
            len1 <= `RDC_LEN1_RST;
        end else if (wr_len1) begin
            len1 <= wd;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst) begin
            len2 <= `RDC_LEN2_RST;
        end else if (wr_len2) begin
            len2 <= wd;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst) begin
            rx_bits <= 5'h00;
        end else if (rx_done_i) begin
            rx_bits <= rx_valid_bits_i;
        end
    end
    assign complete_byte_count_o = {len1, len2[7:`RDC_CNT_LSB]};
    assign partial_flag_o = len2[`RDC_FLAG_POS];
    assign partial_byte_bits_o = partial_flag_o ? len2[3:`RDC_BITS_LSB] : 3'h0;

    // options and test setting
    always_ff @(posedge clk_i) begin
        if (rst) begin
            msel <= 3'h0;
            opt_hp <= 1'b0;
        end else begin
            if (wr_done & hit(ix, `RDC_IX_TST)) msel <= wd[2:0];
            if (wr_done & hit(ix, `RDC_IX_OPT)) opt_hp <= wd[`RDC_OPT_HP_POS];
        end
    end
    assign adc_msel_o = msel;
    assign adc_test_o = (msel != `RDC_MSEL_MIX1) & (msel != `RDC_MSEL_MIX2)
        & (msel != `RDC_MSEL_PIN);

    // hop selection and receiver block
    always_ff @(posedge clk_i) begin
        if (rst | c_main) begin
            aux <= 1'b0;
        end else if (c_aux) begin
            aux <= 1'b1;
        end
    end
    assign pll_aux_sel_o = aux;
    // block command wins over a transmit end in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst) begin
            rxb <= 1'b0;
        end else if (c_rxb) begin
            rxb <= 1'b1;
        end else if (c_rxe | tx_eof_i) begin
            rxb <= 1'b0;
        end
    end
    assign rx_block_o = rxb;

    // transmit command attributes, held until next transmit command
    always_ff @(posedge clk_i) begin
        if (rst) begin
            tx_start_o <= 1'b0;
            tx_cmd_o <= 8'h00;
            tx_crc16_o <= 1'b0;
            tx_crc5_o <= 1'b0;
            rx_crc_off_o <= 1'b0;
            header_bit_o <= 1'b0;
            tx_delayed_o <= 1'b0;
        end else begin
            tx_start_o <= tx_go;
            if (tx_go) begin
                tx_cmd_o <= wd;
                tx_crc16_o <= (wd <= `RDC_C_TX_HDR) | (wd == `RDC_C_DLY_CRC);
                tx_crc5_o <= (wd == `RDC_C_QUERY);
                rx_crc_off_o <= tx_hi & (wd <= `RDC_C_QADJ_DN);
                header_bit_o <= (wd == `RDC_C_TX_HDR);
                tx_delayed_o <= (wd == `RDC_C_DLY_NOCRC) | (wd == `RDC_C_DLY_CRC);
            end
        end
    end

    // adc and calibration sequencer
    logic [8:0] cnt;
    wire cnt_end = (cnt == 9'h000);
    always_ff @(posedge clk_i) begin
        if (rst) begin
            state <= st_idle;
            cnt <= 9'h000;
        end else begin
            unique case (state)
                st_idle: begin
                    cnt <= 9'(ADC_CYCLES - 1);
                    if (c_adc) state <= st_adc;
                    else if (c_cal) state <= st_cal;
                end
                st_adc: begin
                    cnt <= cnt - 9'h001;
                    if (cnt_end) state <= st_idle;
                end
                st_cal: begin
                    if (cal_done_i) state <= st_idle;
                end
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        adc_start_o <= ~rst & c_adc;
        cal_start_o <= ~rst & c_cal;
    end
    always_ff @(posedge clk_i) begin
        if (rst) begin
            adc_reg <= 8'h00;
        end else if ((state == st_adc) & cnt_end) begin
            adc_reg <= adc_data_i;
        end
    end
    assign seq_state_o = state;

    // calibration steps saturate; each section has its own nibble
    wire dn_lp = c_dn & ~opt_hp & (lp != 4'h0);
    wire up_lp = c_up & ~opt_hp & (lp != `RDC_CAL_MAX);
    wire dn_hp = c_dn & opt_hp & (hp != 4'h0);
    wire up_hp = c_up & opt_hp & (hp != `RDC_CAL_MAX);
    wire cal_ld = (state == st_cal) & cal_done_i;
    always_ff @(posedge clk_i) begin
        if (rst) begin
            {hp, lp} <= `RDC_CAL_RST;
        end else if (cal_ld) begin
            {hp, lp} <= cal_result_i;
        end else begin
            lp <= lp - {3'h0, dn_lp} + {3'h0, up_lp};
            hp <= hp - {3'h0, dn_hp} + {3'h0, up_hp};
        end
    end
    assign cal_lp_o = lp;
    assign cal_hp_o = hp;

    // fifo: host side has priority over link side on push; host and link pops merge into one pop
    logic [7:0] mem [DEPTH];
    logic [4:0] wp;
    logic [4:0] rp;
    logic [4:0] count;
    wire full = (count == 5'(DEPTH));
    wire empty = (count == 5'h00);
    wire h_push = wr_done & hit(ix, `RDC_IX_FIFO);
    wire h_pop = rd_done & hit(ix, `RDC_IX_FIFO);
    wire push = (h_push | rx_push_i) & ~full;
    wire pop = (h_pop | tx_pop_i) & ~empty;
    wire [7:0] push_d = h_push ? wd : rx_data_i;
    function automatic logic [4:0] nxt(input logic [4:0] p);
        nxt = (p == 5'(DEPTH - 1)) ? 5'h00 : p + 5'h01;
    endfunction
    always_ff @(posedge clk_i) begin
        if (rst | c_frst) begin
            wp <= 5'h00;
            rp <= 5'h00;
            count <= 5'h00;
        end else begin
            if (push) wp <= nxt(wp);
            if (pop) rp <= nxt(rp);
            count <= count + {4'h0, push} - {4'h0, pop};
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) mem[wp] <= push_d;
    end
    // interrupt flags and collision store sit outside; they clear on this pulse
    always_ff @(posedge clk_i) begin
        fifo_reset_o <= ~rst & c_frst;
    end
    assign tx_data_o = mem[rp];
    assign fifo_count_o = count;

    // read mux; command and unmapped words read zero
    wire [7:0] stat = {4'h0, ~idle_st, rxb, state == st_cal, aux};
    wire [7:0] rd_mux =
        hit(ix, `RDC_IX_LEN1) ? len1 :
        hit(ix, `RDC_IX_LEN2) ? {3'h0, rx_bits} :
        hit(ix, `RDC_IX_FIFO) ? (empty ? 8'h00 : mem[rp]) :
        hit(ix, `RDC_IX_CAL) ? {hp, lp} :
        hit(ix, `RDC_IX_TST) ? {5'h00, msel} :
        hit(ix, `RDC_IX_OPT) ? {7'h00, opt_hp} :
        hit(ix, `RDC_IX_ADC) ? adc_reg :
        hit(ix, `RDC_IX_STAT) ? stat : 8'h00;
    always_ff @(posedge clk_i) begin
        if (rst) begin
            avm_readdata_o <= 32'h0000_0000;
        end else if (take & avm_read_i) begin
            avm_readdata_o <= {24'h00_0000, rd_mux};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst);

    property p_len1_eof;
        tx_eof_i |=> (complete_byte_count_o[11:4] == 8'h00);
    endproperty
    a_len1_eof: assert property (p_len1_eof) else $error("len1 kept after eof");
    property p_len2_hidden;
        (rd_done & hit(ix, `RDC_IX_LEN2)) |-> (avm_readdata_o[7:5] == 3'h0);
    endproperty
    a_len2_hidden: assert property (p_len2_hidden) else $error("len2 read back");
    property p_rx_bits;
        rx_done_i |=> (rx_bits == $past(rx_valid_bits_i));
    endproperty
    a_rx_bits: assert property (p_rx_bits) else $error("rx bits not stored");
    property p_partial;
        !partial_flag_o |-> (partial_byte_bits_o == 3'h0);
    endproperty
    a_partial: assert property (p_partial) else $error("partial bits leak");
    property p_hop;
        c_aux |=> pll_aux_sel_o ##1 (pll_aux_sel_o || $past(c_main));
    endproperty
    a_hop: assert property (p_hop) else $error("aux hop lost");
    sequence s_adc_run;
        adc_start_o ##0 (state == st_adc) [*8];
    endsequence
    property p_adc;
        c_adc |=> s_adc_run;
    endproperty
    a_adc: assert property (p_adc) else $error("adc conversion not held");
    property p_step_dn;
        (c_dn & ~opt_hp & lp != 4'h0) |=> (lp == $past(lp) - 4'h1) && (hp == $past(hp));
    endproperty
    a_step_dn: assert property (p_step_dn) else $error("lp step down wrong");
    property p_step_up;
        (c_up & opt_hp) |=> (hp == (($past(hp) == 4'hf) ? 4'hf : $past(hp) + 4'h1));
    endproperty
    a_step_up: assert property (p_step_up) else $error("hp step up wrong");
    property p_frst;
        c_frst |=> (fifo_count_o == 5'h00) && fifo_reset_o;
    endproperty
    a_frst: assert property (p_frst) else $error("fifo reset failed");
    // low nibble of the joined count must follow the last register two write
    property p_count;
        wr_len2 |=> (complete_byte_count_o[3:0] == $past(wd[7:4]));
    endproperty
    a_count: assert property (p_count) else $error("count join wrong");
endmodule

/* verification/rdc_link_model.sv */
// Purpose: link side model answering calibration and transmit starts
// Assumes: start strobes from the block are one-cycle pulses on clk_i
// Notes: result bus carries inverted data outside the done pulse
module rdc_link_model #(
    parameter int CAL_DELAY = 5,
    parameter int TX_DELAY = 6,
    parameter logic [7:0] CAL_RESULT = 8'h30,
    parameter logic [7:0] ADC_VALUE = 8'h5a
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cal_start_i,
    input wire logic tx_start_i,
    output logic cal_done_o,
    output logic [7:0] cal_result_o,
    output logic tx_eof_o,
    output logic [7:0] adc_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cal_cnt;
    int tx_cnt;
    assign adc_data_o = ADC_VALUE;
    // not held after done, so a late capture sees wrong data
    assign cal_result_o = cal_done_o ? CAL_RESULT : ~CAL_RESULT;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cal_cnt <= 0;
            tx_cnt <= 0;
            cal_done_o <= 1'b0;
            tx_eof_o <= 1'b0;
        end else begin
            cal_cnt <= cal_start_i ? CAL_DELAY : (cal_cnt > 0 ? cal_cnt - 1 : 0);
            tx_cnt <= tx_start_i ? TX_DELAY : (tx_cnt > 0 ? tx_cnt - 1 : 0);
            cal_done_o <= (cal_cnt == 1);
            tx_eof_o <= (tx_cnt == 1);
        end
    end
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench for the direct command block
// Assumes: avalon slave answers after one wait, short adc count
// Notes: link side answered by rdc_link_model
`include "rdc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rdc_pkg::*;
    logic clk_i, reset_i, enable_i, avm_read_i, avm_write_i, rx_done_i, rx_push_i, tx_pop_i;
    logic [7:0] avm_address_i, rx_data_i, tx_data_o, tx_cmd_o, adc_data_i, cal_result_i, q;
    logic [31:0] avm_writedata_i, avm_readdata_o;
    logic [4:0] rx_valid_bits_i, fifo_count_o;
    logic avm_waitrequest_o, tx_eof_i, cal_done_i, partial_flag_o, pll_aux_sel_o, adc_start_o;
    logic adc_test_o, cal_start_o, rx_block_o, fifo_reset_o, tx_start_o, tx_crc16_o;
    logic tx_crc5_o, rx_crc_off_o, header_bit_o, tx_delayed_o;
    logic [11:0] complete_byte_count_o;
    logic [2:0] partial_byte_bits_o, adc_msel_o;
    logic [3:0] cal_lp_o, cal_hp_o;
    rdc_state_type seq_state_o;
    int error_cnt = 0;
    int tests_run = 0;
    // attrs: check, crc16, crc5, rx crc off, header bit, delayed
    logic [7:0] tx_code [13] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h98, 8'h99, 8'h9a,
        8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f};
    logic [5:0] tx_attr [13] = '{6'h30, 6'h32, 6'h20, 6'h21, 6'h31, 6'h2c, 6'h24, 6'h24,
        6'h24, 6'h24, 6'h20, 6'h20, 6'h20};
    logic [7:0] ign_code [3] = '{8'h80, 8'h86, 8'h07};

    rdc_core #(.ADC_CYCLES(10)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
        .avm_address_i(avm_address_i), .avm_read_i(avm_read_i), .avm_write_i(avm_write_i),
        .avm_writedata_i(avm_writedata_i), .avm_readdata_o(avm_readdata_o),
        .avm_waitrequest_o(avm_waitrequest_o), .tx_eof_i(tx_eof_i), .rx_done_i(rx_done_i),
        .rx_valid_bits_i(rx_valid_bits_i), .rx_push_i(rx_push_i), .rx_data_i(rx_data_i),
        .tx_pop_i(tx_pop_i), .tx_data_o(tx_data_o), .fifo_count_o(fifo_count_o),
        .adc_data_i(adc_data_i), .cal_done_i(cal_done_i), .cal_result_i(cal_result_i),
        .complete_byte_count_o(complete_byte_count_o), .partial_flag_o(partial_flag_o),
        .partial_byte_bits_o(partial_byte_bits_o), .pll_aux_sel_o(pll_aux_sel_o),
        .adc_start_o(adc_start_o), .adc_msel_o(adc_msel_o), .adc_test_o(adc_test_o),
        .cal_start_o(cal_start_o), .cal_lp_o(cal_lp_o), .cal_hp_o(cal_hp_o),
        .rx_block_o(rx_block_o), .fifo_reset_o(fifo_reset_o), .tx_start_o(tx_start_o),
        .tx_cmd_o(tx_cmd_o), .tx_crc16_o(tx_crc16_o), .tx_crc5_o(tx_crc5_o),
        .rx_crc_off_o(rx_crc_off_o), .header_bit_o(header_bit_o),
        .tx_delayed_o(tx_delayed_o), .seq_state_o(seq_state_o));

    rdc_link_model link_u (.clk_i(clk_i), .reset_i(reset_i), .cal_start_i(cal_start_o),
        .tx_start_i(tx_start_o), .cal_done_o(cal_done_i), .cal_result_o(cal_result_i),
        .tx_eof_o(tx_eof_i), .adc_data_o(adc_data_i));

    task automatic final_report;
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(input logic is_wr, input logic [5:0] ix, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        avm_address_i <= {ix, 2'b00};
        avm_writedata_i <= {24'h0, d};
        avm_write_i <= is_wr;
        avm_read_i <= !is_wr;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avm_waitrequest_o !== 1'b0 && n < 50);
        if (avm_waitrequest_o !== 1'b0) begin
            error_cnt++;
            final_report;
        end else begin
            q = avm_readdata_o[7:0];
            avm_write_i <= 1'b0;
            avm_read_i <= 1'b0;
        end
    endtask

    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        bus(1'b1, ix, d);
    endtask

    task automatic rd(input logic [5:0] ix, input logic [7:0] exp, input string nm);
        bus(1'b0, ix, 8'h00);
        chk(nm, exp, q);
    endtask

    // leaves us mid-cycle in which command pulses stand
    task automatic cmd(input logic [7:0] c);
        wr(`RDC_IX_CMD, c);
        @(negedge clk_i);
    endtask

    task automatic wait_idle;
        for (int n = 0; n < 100 && seq_state_o !== st_idle; n++)
            @(negedge clk_i);
        chk("seq_idle", st_idle, seq_state_o);
        if (seq_state_o !== st_idle)
            final_report;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        {reset_i, enable_i} = 2'b11;
        {avm_read_i, avm_write_i, rx_done_i, rx_push_i, tx_pop_i} = '0;
        {avm_address_i, rx_data_i, avm_writedata_i, rx_valid_bits_i} = '0;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(`RDC_IX_LEN1, 8'h00, "len1_rst");
        rd(`RDC_IX_LEN2, 8'h00, "len2_rst");
        chk("aux_rst", 0, pll_aux_sel_o);
        wr(`RDC_IX_LEN1, 8'hab);
        wr(`RDC_IX_LEN2, 8'hcb);
        @(negedge clk_i);
        chk("count", 12'habc, complete_byte_count_o);
        chk("pflag", 1, partial_flag_o);
        chk("pbits", 5, partial_byte_bits_o);
        rd(`RDC_IX_LEN2, 8'h00, "len2_wo");
        wr(`RDC_IX_LEN2, 8'hca);
        @(negedge clk_i);
        chk("pbits_off", 0, partial_byte_bits_o);
        @(posedge clk_i);
        rx_done_i <= 1'b1;
        rx_valid_bits_i <= 5'h13;
        @(posedge clk_i);
        rx_done_i <= 1'b0;
        rd(`RDC_IX_LEN2, 8'h13, "rx_bits");
        wr(6'h30, 8'hff);
        rd(6'h30, 8'h00, "unmapped");
        @(posedge clk_i);
        rx_push_i <= 1'b1;
        rx_data_i <= 8'ha5;
        @(posedge clk_i);
        rx_push_i <= 1'b0;
        @(negedge clk_i);
        chk("rx_push", 8'ha5, tx_data_o);
        @(posedge clk_i);
        tx_pop_i <= 1'b1;
        @(posedge clk_i);
        tx_pop_i <= 1'b0;
        @(negedge clk_i);
        chk("pop_cnt", 0, fifo_count_o);
        for (int i = 0; i < 25; i++)
            wr(`RDC_IX_FIFO, 8'h10 + i[7:0]);
        @(negedge clk_i);
        chk("fifo_full", 24, fifo_count_o);
        for (int i = 0; i < 24; i++)
            rd(`RDC_IX_FIFO, 8'h10 + i[7:0], "fifo_data");
        rd(`RDC_IX_FIFO, 8'h00, "fifo_empty");
        wr(`RDC_IX_FIFO, 8'h77);
        cmd(`RDC_C_FIFO_RST);
        chk("fifo_rst", 1, fifo_reset_o);
        @(negedge clk_i);
        chk("fifo_clr", 0, fifo_count_o);
        for (int i = 0; i < 13; i++) begin
            cmd(tx_code[i]);
            chk("tx_start", 1, tx_start_o);
            chk("tx_cmd", tx_code[i], tx_cmd_o);
            if (tx_attr[i][5])
                chk("tx_attr", tx_attr[i][4:0], {tx_crc16_o, tx_crc5_o, rx_crc_off_o,
                    header_bit_o, tx_delayed_o});
            @(negedge clk_i);
            chk("tx_pulse", 0, tx_start_o);
        end
        for (int i = 0; i < 3; i++) begin
            cmd(ign_code[i]);
            chk("ignored", 0, {tx_start_o, adc_start_o, cal_start_o, fifo_reset_o});
        end
        cmd(`RDC_C_HOP_AUX);
        chk("aux", 1, pll_aux_sel_o);
        cmd(`RDC_C_RX_BLOCK);
        chk("rx_block", 1, rx_block_o);
        chk("aux_kept", 1, pll_aux_sel_o);
        rd(`RDC_IX_STAT, 8'h05, "stat");
        cmd(`RDC_C_RX_EN);
        chk("rx_en", 0, rx_block_o);
        cmd(`RDC_C_HOP_MAIN);
        chk("main", 0, pll_aux_sel_o);
        wr(`RDC_IX_LEN1, 8'h5c);
        @(negedge clk_i);
        chk("count2", 12'h5cc, complete_byte_count_o);
        cmd(`RDC_C_TX_CRC);
        repeat (12) @(negedge clk_i);
        rd(`RDC_IX_LEN1, 8'h00, "len1_eof");
        chk("count_eof", 12'h00c, complete_byte_count_o);
        for (int i = 0; i < 8; i++) begin
            wr(`RDC_IX_TST, i[7:0]);
            @(negedge clk_i);
            chk("msel", i[2:0], adc_msel_o);
            chk("adc_test", !(i inside {1, 2, 3}), adc_test_o);
        end
        wr(`RDC_IX_TST, 8'h03);
        cmd(`RDC_C_ADC);
        chk("adc_start", 1, adc_start_o);
        chk("adc_busy", st_adc, seq_state_o);
        wait_idle;
        rd(`RDC_IX_ADC, 8'h5a, "adc_read");
        cmd(`RDC_C_CAL);
        chk("cal_start", 1, cal_start_o);
        wait_idle;
        rd(`RDC_IX_CAL, 8'h30, "cal_read");
        cmd(`RDC_C_CAL_UP);
        rd(`RDC_IX_CAL, 8'h31, "cal_up");
        cmd(`RDC_C_CAL_DN);
        rd(`RDC_IX_CAL, 8'h30, "cal_dn");
        cmd(`RDC_C_CAL_DN);
        rd(`RDC_IX_CAL, 8'h30, "cal_floor");
        wr(`RDC_IX_OPT, 8'h01);
        cmd(`RDC_C_CAL_DN);
        rd(`RDC_IX_CAL, 8'h20, "cal_hp_dn");
        chk("hp_out", 2, cal_hp_o);
        chk("lp_out", 0, cal_lp_o);
        cmd(`RDC_C_CAL_UP);
        rd(`RDC_IX_CAL, 8'h30, "cal_hp_up");
        // enable low mid-run acts as reset of every block register except the fifo storage
        wr(`RDC_IX_LEN1, 8'h42);
        cmd(`RDC_C_HOP_AUX);
        @(posedge clk_i);
        enable_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        enable_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(`RDC_IX_LEN1, 8'h00, "len1_en");
        chk("main_en", 0, pll_aux_sel_o);
        rd(`RDC_IX_CAL, 8'h00, "cal_en");
        final_report;
    end
endmodule
